// ---- rtl/drs_defs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef DRS_DEFS_SVH
`define DRS_DEFS_SVH

// Register word offsets (byte addresses)
`define DRS_REG_CTRL      8'h00
`define DRS_REG_RELAY     8'h04
`define DRS_REG_INPUT     8'h08
`define DRS_REG_PLANT     8'h0C
`define DRS_REG_STATUS    8'h10
`define DRS_REG_ONDELAY   8'h14
`define DRS_REG_ADDR_W    8

// CTRL fields
`define DRS_CTRL_MANDIS   0
`define DRS_CTRL_SYSCFG_L 4
`define DRS_CTRL_SYSCFG_H 6
`define DRS_CTRL_CLEAR    8
`define DRS_CTRL_RESET    32'h0000_0001
`define DRS_SYSCFG_W      3
`define DRS_SYSCFG_ONOFF  3'h0

// RELAY fields
`define DRS_RLY1_L        0
`define DRS_RLY1_H        2
`define DRS_RLY2_L        4
`define DRS_RLY2_H        6
`define DRS_RLY_BUS1      8
`define DRS_RLY_BUS2      9
`define DRS_RLY_MAX1      3'h7
`define DRS_RLY_MAX2      3'h6
`define DRS_RLY_RESET     3'h0

// INPUT fields
`define DRS_IN1_L         0
`define DRS_IN1_H         1
`define DRS_IN2_L         4
`define DRS_IN2_H         5
`define DRS_IN_RESET      2'h1

// PLANT fields
`define DRS_PL_FAULT      0
`define DRS_PL_PUMPFLT    1
`define DRS_PL_FREQNZ     2
`define DRS_PL_ATMIN      3
`define DRS_PL_LAG        4

// Operating modes in CTRL
`define DRS_MODE_L        12
`define DRS_MODE_H        13

// STATUS fields
`define DRS_ST_RUN        0
`define DRS_ST_LATCH1     1
`define DRS_ST_LATCH2     2
`define DRS_ST_RELAY1     3
`define DRS_ST_RELAY2     4
`define DRS_ST_OUTEN      5
`define DRS_ST_OILER      6
`define DRS_ST_MODE_L     8

// Timing: clock 40 MHz, debounce 1 ms
`define DRS_CLK_HZ        40000000
`define DRS_DEBOUNCE_US   1000
`define DRS_DEBOUNCE_CYC  ((`DRS_CLK_HZ / 1000000) * `DRS_DEBOUNCE_US)
`define DRS_DB_W          16
`define DRS_ONDELAY_RESET 32'h0000_0064
`define DRS_ONDELAY_W     32

`endif

// ---- rtl/drs_pkg.sv ----
// Types shared by the relay and input select logic
package drs_pkg;
    typedef enum logic [1:0] {
        DRS_MODE_OFF    = 2'h0,
        DRS_MODE_AUTO   = 2'h1,
        DRS_MODE_MANUAL = 2'h2
    } drs_mode_e;

    typedef enum logic [2:0] {
        DRS_OIL_IDLE  = 3'b001,
        DRS_OIL_DELAY = 3'b010,
        DRS_OIL_RUN   = 3'b100
    } drs_oil_e;
endpackage

// ---- rtl/drs_debounce.sv ----
// Contact input synchroniser and debounce filter
`timescale 1ns/1ps
`include "drs_defs.svh"

module drs_debounce (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic raw_i,
    output logic      clean_o
);
    logic                 sync_a;
    logic                 sync_b;
    logic [`DRS_DB_W-1:0] count;
    wire                  differs = sync_b != clean_o;
    wire                  settled = count ==
        (`DRS_DB_W)'(`DRS_DEBOUNCE_CYC - 1);

    // Two-stage synchroniser; first stage read only by second
    always_ff @(posedge clk_i) begin
        sync_a <= rst_i ? 1'b0 : raw_i;
        sync_b <= rst_i ? 1'b0 : sync_a;
    end

    // Output follows only after the input holds steady
    always_ff @(posedge clk_i) begin
        if (rst_i || !differs) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
        if (rst_i) begin
            clean_o <= 1'b0;
        end else if (differs && settled) begin
            clean_o <= sync_b;
        end
    end
endmodule

// ---- rtl/drs_input.sv ----
// One programmable contact input: run decode and latching stop fault
`timescale 1ns/1ps
`include "drs_defs.svh"

module drs_input (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       closed_i,
    input  wire logic [1:0] func_i,
    input  wire logic       clear_i,
    output logic            run_o,
    output logic            latch_o
);
    // Latch sets on open in code 3; ENTER clears, but a set wins
    wire trip = (func_i == 2'h3) && !closed_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_o <= 1'b0;
        end else if (trip) begin
            latch_o <= 1'b1;
        end else if (clear_i) begin
            latch_o <= 1'b0;
        end
    end

    // Run request per selected function
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_o <= 1'b0;
        end else begin
            unique case (func_i)
                2'h0: run_o <= closed_i;
                2'h1: run_o <= !closed_i;
                2'h2: run_o <= 1'b1;
                2'h3: run_o <= closed_i && !latch_o && !trip;
            endcase
        end
    end
endmodule

// ---- rtl/drs_top.sv ----
// Relay output and contact input select logic with Wishbone registers
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "drs_defs.svh"

module drs_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Contacts and keypad
    input  wire logic        run_input_one_i,
    input  wire logic        run_input_two_i,
    input  wire logic        enter_key_i,
    // Relays and status
    output logic             relay_one_closed_contact_o,
    output logic             relay_one_open_contact_o,
    output logic             relay_two_open_contact_o,
    output logic             run_o,
    output logic             output_enable_o,
    output logic             input_fault_o
);
    // Software registers
    logic                          manual_dis;
    logic [`DRS_SYSCFG_W-1:0]      sys_cfg;
    logic [1:0]                    mode_req;
    logic [2:0]                    rly1_func;
    logic [2:0]                    rly2_func;
    logic                          bus_rly1;
    logic                          bus_rly2;
    logic [1:0]                    in1_func;
    logic [1:0]                    in2_func;
    logic [4:0]                    plant;
    logic [`DRS_ONDELAY_W-1:0]     on_delay;
    logic                          sw_clear;

    // Plant condition bits written by the drive firmware
    wire drv_fault = plant[`DRS_PL_FAULT];
    wire pump_flt  = plant[`DRS_PL_PUMPFLT];
    wire freq_nz   = plant[`DRS_PL_FREQNZ];
    wire at_min    = plant[`DRS_PL_ATMIN];
    wire lag_req   = plant[`DRS_PL_LAG];

    // Bus decode
    wire        req     = cyc_i && stb_i && !ack_o;
    wire        wr      = req && we_i && sel_i[0];
    wire        wr_ctrl = wr && adr_i == `DRS_REG_CTRL;
    wire        wr_rly  = wr && adr_i == `DRS_REG_RELAY;
    wire        wr_in   = wr && adr_i == `DRS_REG_INPUT;
    wire        wr_pl   = wr && adr_i == `DRS_REG_PLANT;
    wire        wr_dly  = wr && adr_i == `DRS_REG_ONDELAY;
    wire [2:0]  new_r1  = dat_i[`DRS_RLY1_H:`DRS_RLY1_L];
    wire [2:0]  new_r2  = dat_i[`DRS_RLY2_H:`DRS_RLY2_L];
    wire [1:0]  new_mode = dat_i[`DRS_MODE_H:`DRS_MODE_L];

    // Selector range check shared by both relays
    function automatic logic code_ok(input logic [2:0] code,
                                     input logic [2:0] max);
        code_ok = code <= max;
    endfunction

    // Manual mode refused while disabled
    wire mode_ok = !(new_mode == drs_pkg::DRS_MODE_MANUAL &&
                     (dat_i[`DRS_CTRL_MANDIS] || (!sel_i[0] && manual_dis)))
                   && new_mode != 2'h3;

    // Bus acknowledge and register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o      <= 1'b0;
            manual_dis <= 1'(`DRS_CTRL_RESET);
            sys_cfg    <= `DRS_SYSCFG_ONOFF;
            mode_req   <= drs_pkg::DRS_MODE_OFF;
            rly1_func  <= `DRS_RLY_RESET;
            rly2_func  <= `DRS_RLY_RESET;
            bus_rly1   <= 1'b0;
            bus_rly2   <= 1'b0;
            in1_func   <= `DRS_IN_RESET;
            in2_func   <= `DRS_IN_RESET;
            plant      <= '0;
            on_delay   <= `DRS_ONDELAY_RESET;
            sw_clear   <= 1'b0;
        end else begin
            ack_o    <= req;
            sw_clear <= wr_ctrl && dat_i[`DRS_CTRL_CLEAR];
            if (wr_ctrl) begin
                manual_dis <= dat_i[`DRS_CTRL_MANDIS];
                sys_cfg    <= dat_i[`DRS_CTRL_SYSCFG_H:`DRS_CTRL_SYSCFG_L];
            end
            if (wr_ctrl && sel_i[1] && mode_ok) begin
                mode_req <= new_mode;
            end
            if (wr_rly && code_ok(new_r1, `DRS_RLY_MAX1)) begin
                rly1_func <= new_r1;
            end
            if (wr_rly && code_ok(new_r2, `DRS_RLY_MAX2)) begin
                rly2_func <= new_r2;
            end
            if (wr_rly && sel_i[1]) begin
                bus_rly1 <= dat_i[`DRS_RLY_BUS1];
                bus_rly2 <= dat_i[`DRS_RLY_BUS2];
            end
            if (wr_in) begin
                in1_func <= dat_i[`DRS_IN1_H:`DRS_IN1_L];
                in2_func <= dat_i[`DRS_IN2_H:`DRS_IN2_L];
            end
            if (wr_pl) begin
                plant <= dat_i[4:0];
            end
            if (wr_dly) begin
                on_delay <= dat_i;
            end
        end
    end

    // A later disable forces an active manual state back to off
    wire [1:0] mode = (manual_dis && mode_req == drs_pkg::DRS_MODE_MANUAL)
                      ? drs_pkg::DRS_MODE_OFF : mode_req;
    wire auto_md = mode == drs_pkg::DRS_MODE_AUTO;
    wire run_md  = mode != drs_pkg::DRS_MODE_OFF;

    // Debounced contacts
    logic in1_clean;
    logic in2_clean;

    drs_debounce u_db1 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (run_input_one_i),
        .clean_o (in1_clean)
    );

    drs_debounce u_db2 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (run_input_two_i),
        .clean_o (in2_clean)
    );

    // Configuration 0 forces plain closed-means-run on both inputs
    wire       cfg0   = sys_cfg == `DRS_SYSCFG_ONOFF;
    wire [1:0] eff_f1 = cfg0 ? 2'h0 : in1_func;
    wire [1:0] eff_f2 = cfg0 ? 2'h0 : in2_func;
    wire       clear  = sw_clear || enter_key_i;

    logic run1;
    logic run2;
    logic latch1;
    logic latch2;

    drs_input u_in1 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .closed_i (in1_clean),
        .func_i   (eff_f1),
        .clear_i  (clear),
        .run_o    (run1),
        .latch_o  (latch1)
    );

    drs_input u_in2 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .closed_i (in2_clean),
        .func_i   (eff_f2),
        .clear_i  (clear),
        .run_o    (run2),
        .latch_o  (latch2)
    );

    // Run needs both inputs and a non-off state
    wire run_cmd = run1 && run2 && run_md;

    // Pre-lube oiler sequence
    drs_pkg::drs_oil_e           oil;
    drs_pkg::drs_oil_e           next_oil;
    logic [`DRS_ONDELAY_W-1:0]   oil_cnt;
    wire  oil_used = rly1_func == 3'h6 || rly2_func == 3'h6;
    wire  oil_done = oil_cnt == '0;

    always_comb begin
        next_oil = oil;
        unique case (oil)
            drs_pkg::DRS_OIL_IDLE:
                if (run_cmd && oil_used) begin
                    next_oil = drs_pkg::DRS_OIL_DELAY;
                end
            drs_pkg::DRS_OIL_DELAY:
                if (!run_cmd) begin
                    next_oil = drs_pkg::DRS_OIL_IDLE;
                end else if (oil_done) begin
                    next_oil = drs_pkg::DRS_OIL_RUN;
                end
            drs_pkg::DRS_OIL_RUN:
                if (!run_cmd) begin
                    next_oil = drs_pkg::DRS_OIL_IDLE;
                end
            default: next_oil = drs_pkg::DRS_OIL_IDLE;
        endcase
    end

    // Oiler state and on-delay countdown
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oil     <= drs_pkg::DRS_OIL_IDLE;
            oil_cnt <= '0;
        end else begin
            oil <= next_oil;
            if (oil == drs_pkg::DRS_OIL_IDLE) begin
                oil_cnt <= on_delay;
            end else if (!oil_done) begin
                oil_cnt <= oil_cnt - 1'b1;
            end
        end
    end

    // Oiler relay on from run until minimum frequency reached
    wire oil_rly = oil != drs_pkg::DRS_OIL_IDLE && !at_min;
    // Drive output held off during the oiler delay
    wire out_ok  = run_cmd && (!oil_used || oil == drs_pkg::DRS_OIL_RUN);

    // Relay state per function code
    function automatic logic relay_fn(input logic [2:0] code,
                                      input logic       bus_cmd);
        unique case (code)
            3'h0: relay_fn = drv_fault;
            3'h1: relay_fn = lag_req;
            3'h2: relay_fn = bus_cmd;
            3'h3: relay_fn = pump_flt;
            3'h4: relay_fn = freq_nz;
            3'h5: relay_fn = in1_clean && auto_md;
            3'h6: relay_fn = oil_rly;
            3'h7: relay_fn = freq_nz;
        endcase
    endfunction

    wire rly1 = relay_fn(rly1_func, bus_rly1);
    wire rly2 = relay_fn(rly2_func, bus_rly2);

    // Read mux
    wire [31:0] status = {23'h0, 1'b0, 1'b0, oil_rly, out_ok, rly2,
                          rly1, latch2, latch1, run_cmd};
    // Mode in bits 13:12, configuration in 6:4, disable in 0
    wire [31:0] rd_ctrl = {18'h0, mode, 5'h0, sys_cfg, 3'h0, manual_dis};
    wire [31:0] rd_rly  = {22'h0, bus_rly2, bus_rly1, 1'b0, rly2_func,
                           1'b0, rly1_func};
    wire [31:0] rd_in   = {26'h0, in2_func, 2'h0, in1_func};
    wire [31:0] rd_data =
        adr_i == `DRS_REG_CTRL    ? rd_ctrl :
        adr_i == `DRS_REG_RELAY   ? rd_rly :
        adr_i == `DRS_REG_INPUT   ? rd_in :
        adr_i == `DRS_REG_PLANT   ? {27'h0, plant} :
        adr_i == `DRS_REG_STATUS  ? status :
        adr_i == `DRS_REG_ONDELAY ? on_delay : 32'h0000_0000;

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o                      <= '0;
            relay_one_closed_contact_o <= 1'b1;
            relay_one_open_contact_o   <= 1'b0;
            relay_two_open_contact_o   <= 1'b0;
            run_o                      <= 1'b0;
            output_enable_o            <= 1'b0;
            input_fault_o              <= 1'b0;
        end else begin
            dat_o                      <= req ? rd_data : '0;
            relay_one_closed_contact_o <= !rly1;
            relay_one_open_contact_o   <= rly1;
            relay_two_open_contact_o   <= rly2;
            run_o                      <= run_cmd;
            output_enable_o            <= out_ok;
            input_fault_o              <= latch1 || latch2;
        end
    end
endmodule

// ---- sim/drs_top_sva.sv ----
// Port-level checker for the relay and input select block
`timescale 1ns/1ps
module drs_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        run_input_one_i,
    input wire logic        run_input_two_i,
    input wire logic        relay_one_closed_contact_o,
    input wire logic        relay_one_open_contact_o,
    input wire logic        run_o,
    input wire logic        output_enable_o,
    input wire logic        input_fault_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus handshake
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    a_ack_has_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");

    // Relay and run outputs
    a_relay_one_pair: assert property (
        relay_one_closed_contact_o != relay_one_open_contact_o)
        else $error("relay one contacts not complementary");
    a_fault_stops_run: assert property (
        input_fault_o && $past(input_fault_o, 2) |-> !run_o)
        else $error("run while input fault latched");
    a_outen_needs_run: assert property (
        $rose(output_enable_o) |-> run_o)
        else $error("output enabled without run");
    a_fault_from_open: assert property (
        $rose(input_fault_o) |-> $past(run_input_one_i, 8) == 1'h0
        || $past(run_input_two_i, 8) == 1'h0)
        else $error("fault raised without open contact");
    a_reset_outputs: assert property (
        disable iff (1'h0) rst_i |=> relay_one_closed_contact_o
        && !relay_one_open_contact_o && !run_o && !input_fault_o)
        else $error("outputs wrong after reset");
endmodule

bind drs_top drs_chk i_chk (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .cyc_i                      (cyc_i),
    .stb_i                      (stb_i),
    .dat_o                      (dat_o),
    .ack_o                      (ack_o),
    .run_input_one_i            (run_input_one_i),
    .run_input_two_i            (run_input_two_i),
    .relay_one_closed_contact_o (relay_one_closed_contact_o),
    .relay_one_open_contact_o   (relay_one_open_contact_o),
    .run_o                      (run_o),
    .output_enable_o            (output_enable_o),
    .input_fault_o              (input_fault_o)
);

// ---- sim/drs_field.sv ----
// Dry contact model for the two programmable inputs
`timescale 1ns/1ps
module drs_field (
    input  wire logic close_one_i,
    input  wire logic close_two_i,
    output logic      run_input_one_o,
    output logic      run_input_two_o
);
    // Closed contact reads high at the terminal
    assign run_input_one_o = close_one_i;
    assign run_input_two_o = close_two_i;
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the relay and input select block
`timescale 1ns/1ps
`include "drs_defs.svh"
module testbench;
    logic        clk   = 1'h0;
    logic        rst   = 1'h1;
    logic        cyc   = 1'h0;
    logic        stb   = 1'h0;
    logic        we    = 1'h0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    logic        cl1   = 1'h1;
    logic        cl2   = 1'h1;
    logic        in1;
    logic        in2;
    logic        enter = 1'h0;
    logic        nc1;
    logic        no1;
    logic        no2;
    logic        run;
    logic        outen;
    logic        fault;
    logic [31:0] q;
    int          err_total = 0;
    int          tests_run = 0;
    logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [31:0] acts  [6] = '{32'h01, 32'h10, 32'h00, 32'h02, 32'h04, 32'h04};

    // Clock
    always #12.5 clk = ~clk;

    drs_field i_field (.close_one_i(cl1), .close_two_i(cl2),
        .run_input_one_o(in1), .run_input_two_o(in2));

    drs_top i_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .run_input_one_i(in1), .run_input_two_i(in2),
        .enter_key_i(enter), .relay_one_closed_contact_o(nc1),
        .relay_one_open_contact_o(no1), .relay_two_open_contact_o(no2),
        .run_o(run), .output_enable_o(outen), .input_fault_o(fault));

    task test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    // Classic single Wishbone cycle, read data left in q
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'h1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we  <= 1'h0;
        if (n == 16) begin
            err_total++;
            $display("CHECK FAILED at %0t: no ack", $time);
            test_done;
        end
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] mask,
                input logic [31:0] exp, input string m);
        wb(1'h0, a, 32'h0000_0000);
        chk(q & mask, exp, m);
    endtask

    function logic sig(input int k);
        case (k)
            0: sig = no1;
            1: sig = no2;
            2: sig = run;
            3: sig = outen;
            default: sig = fault;
        endcase
    endfunction

    // Bounded wait for an output level, then compare
    task wait_sig(input int k, input logic v, input int lim, input string m);
        int n;
        n = 0;
        while (sig(k) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, sig(k)}, {31'h0, v}, m);
    endtask

    // Idle with bus bit set except on code 2, then active condition
    task relay_case(input int rn, input logic [2:0] c, input logic [31:0] act);
        logic [31:0] f;
        logic [31:0] b;
        f = rn ? {25'h0, c, 4'h0} : {29'h0, c};
        b = rn ? 32'h0000_0200 : 32'h0000_0100;
        wb(1'h1, `DRS_REG_RELAY, f | (c != 3'h2 ? b : 32'h0));
        wb(1'h1, `DRS_REG_PLANT, 32'h0000_0000);
        wait_sig(rn, 1'h0, 8, "relay idle");
        wb(1'h1, `DRS_REG_RELAY, f | (c == 3'h2 ? b : 32'h0));
        wb(1'h1, `DRS_REG_PLANT, act);
        wait_sig(rn, 1'h1, 8, "relay active");
        wb(1'h1, `DRS_REG_PLANT, 32'h0000_0000);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        rd_chk(`DRS_REG_CTRL, 32'h3071, 32'h0001, "ctrl reset");
        rd_chk(`DRS_REG_RELAY, 32'h77, 32'h00, "relay reset");
        rd_chk(`DRS_REG_INPUT, 32'h33, 32'h11, "input reset");
        rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0, "unmapped read");
        wb(1'h1, 8'h40, 32'hFFFF_FFFF);
        rd_chk(`DRS_REG_RELAY, 32'h77, 32'h00, "unmapped write");
        wb(1'h1, `DRS_REG_RELAY, 32'h70);
        rd_chk(`DRS_REG_RELAY, 32'h77, 32'h00, "relay two 7");
        wb(1'h1, `DRS_REG_RELAY, 32'h67);
        rd_chk(`DRS_REG_RELAY, 32'h77, 32'h67, "top codes");
        wb(1'h1, `DRS_REG_INPUT, 32'h33);
        rd_chk(`DRS_REG_INPUT, 32'h33, 32'h33, "input code 3");
        wb(1'h1, `DRS_REG_CTRL, 32'h2001);
        rd_chk(`DRS_REG_CTRL, 32'h3001, 32'h0001, "manual refused");
        wb(1'h1, `DRS_REG_CTRL, 32'h2000);
        rd_chk(`DRS_REG_CTRL, 32'h3001, 32'h2000, "manual allowed");
        wb(1'h1, `DRS_REG_CTRL, 32'h1001);
        repeat (4) @(posedge clk);
        chk({31'h0, run}, 32'h0, "contact before debounce");
        // Input one opens before its first closure settles, so the
        // debounced level never rises and one filter period is saved
        cl1 <= 1'h0;
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            relay_case(0, codes[i], acts[i]);
        end
        for (int i = 0; i < 5; i++) begin
            relay_case(1, codes[i], acts[i]);
        end
        $display("test relays done");
        wb(1'h1, `DRS_REG_INPUT, 32'h23);
        wb(1'h1, `DRS_REG_CTRL, 32'h1011);
        wait_sig(4, 1'h1, 8, "latch on open");
        wait_sig(2, 1'h0, 8, "stop on open");
        // Reclose; the damper relay shows when the filter passes it
        cl1 <= 1'h1;
        wb(1'h1, `DRS_REG_RELAY, 32'h05);
        repeat (39000) @(posedge clk);
        chk({31'h0, no1}, 32'h0, "reclose filtered");
        repeat (1100) @(posedge clk);
        wait_sig(0, 1'h1, 8, "damper in auto");
        wait_sig(2, 1'h0, 1, "stays stopped");
        wb(1'h1, `DRS_REG_CTRL, 32'h0011);
        wait_sig(0, 1'h0, 8, "damper off mode");
        wb(1'h1, `DRS_REG_CTRL, 32'h1011);
        enter <= 1'h1;
        repeat (4) @(posedge clk);
        enter <= 1'h0;
        wait_sig(4, 1'h0, 8, "enter clears");
        wait_sig(2, 1'h1, 8, "run after clear");
        wait_sig(2, 1'h1, 1, "latch mode run");
        wb(1'h1, `DRS_REG_INPUT, 32'h10);
        wait_sig(2, 1'h0, 8, "inverted stops");
        wb(1'h1, `DRS_REG_INPUT, 32'h20);
        wait_sig(2, 1'h1, 8, "always run");
        wb(1'h1, `DRS_REG_INPUT, 32'h10);
        wait_sig(2, 1'h0, 8, "inverted again");
        wb(1'h1, `DRS_REG_CTRL, 32'h1001);
        wait_sig(2, 1'h1, 8, "config override");
        // Inverted codes would stop; configuration 0 keeps closed-run
        wb(1'h1, `DRS_REG_INPUT, 32'h11);
        repeat (4) @(posedge clk);
        chk({31'h0, run}, 32'h1, "run both closed");
        $display("test inputs done");
        wb(1'h1, `DRS_REG_CTRL, 32'h0001);
        wb(1'h1, `DRS_REG_ONDELAY, 32'h14);
        wb(1'h1, `DRS_REG_RELAY, 32'h06);
        wb(1'h1, `DRS_REG_CTRL, 32'h1001);
        wait_sig(0, 1'h1, 8, "oiler on run");
        repeat (8) @(posedge clk);
        chk({31'h0, outen}, 32'h0, "on-delay running");
        wait_sig(3, 1'h1, 40, "output after delay");
        wb(1'h1, `DRS_REG_PLANT, 32'h08);
        wait_sig(0, 1'h0, 8, "oiler off at min");
        wb(1'h1, `DRS_REG_PLANT, 32'h00);
        wb(1'h1, `DRS_REG_RELAY, 32'h00);
        $display("test oiler done");
        test_done;
    end
endmodule
